// ---- mic_magnetometer_interrupt_controller.sv ----
`timescale 1ns/1ps

module mic_magnetometer_interrupt_controller
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire mic_axi_req_type axi_req,
    output mic_axi_rsp_type axi_rsp,
    input wire logic sample_valid,
    input wire mic_sample_type sample,
    output logic field_event_pin_out,
    output logic field_event_pin_oe,
    output logic sample_ready_pin_out,
    output logic sample_ready_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // all state of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_full;
        logic [7:0] aw_idx;
        logic w_full;
        logic [7:0] w_data;
        logic w_strb0;
        logic [7:0] axis_en;
        logic [7:0] pin_cfg;
        logic [7:0] low_thr;
        logic [7:0] high_thr;
        logic latch;
        logic [2:0] low_st;
        logic [2:0] high_st;
        logic ovf_st;
        logic rdy_st;
        mic_sample_type data;
        logic evt_out;
        logic evt_oe;
        logic rdy_out;
        logic rdy_oe;
    } mic_state_type;

    mic_state_type st_ff;
    mic_state_type nxt_st;

    logic [7:0] rd_idx;
    logic rd_clr_evt;
    logic rd_end_data;
    logic [7:0] rd_byte;
    logic [15:0] rd_half;
    logic evt_clr;
    logic [2:0] low_en;
    logic [2:0] high_en;
    logic [2:0] low_cond;
    logic [2:0] high_cond;
    logic ovf_cond;
    logic evt_active;
    logic signed [15:0] low_lim;
    logic signed [15:0] high_lim;
    logic [15:0] axis_val [3];
    logic [2:0] axis_ovf;

    ////////////////////////////////////////////////////////////////////////
    // address decode shared by the read and the write path
    function automatic logic reg_mapped(input logic [7:0] idx);
        unique case (idx)
            MIC_IDX_DATA_X, MIC_IDX_DATA_Y, MIC_IDX_DATA_Z, MIC_IDX_HALL,
            MIC_IDX_SAMPLE_READY, MIC_IDX_EVENT_STATUS, MIC_IDX_AXIS_ENABLE,
            MIC_IDX_PIN_CONFIG, MIC_IDX_LOW_THR, MIC_IDX_HIGH_THR:
                reg_mapped = 1'b1;
            default:
                reg_mapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // threshold limits, sign-extended then scaled by sixteen
    assign low_lim = 16'(signed'({{4{st_ff.low_thr[7]}}, st_ff.low_thr,
        4'h0}));
    assign high_lim = 16'(signed'({{4{st_ff.high_thr[7]}}, st_ff.high_thr,
        4'h0}));
    assign low_en = ~st_ff.axis_en[MIC_EN_LOW_LSB +: 3];
    assign high_en = ~st_ff.axis_en[MIC_EN_HIGH_LSB +: 3];

    assign axis_val[0] = sample.x;
    assign axis_val[1] = sample.y;
    assign axis_val[2] = sample.z;
    assign axis_ovf[0] = (sample.x == MIC_OVF_XY);
    assign axis_ovf[1] = (sample.y == MIC_OVF_XY);
    assign axis_ovf[2] = (sample.z == MIC_OVF_Z);
    assign ovf_cond = |axis_ovf;

    // per-axis comparators; z overflow code still counts as low
    generate
        for (genvar a = 0; a < 3; a++) begin : g_axis
            if (a < 2) begin : g_xy
                assign low_cond[a] = ($signed(axis_val[a]) < low_lim)
                    && !axis_ovf[a];
            end else begin : g_z
                assign low_cond[a] = ($signed(axis_val[a]) < low_lim);
            end
            assign high_cond[a] = ($signed(axis_val[a]) > high_lim);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_st = st_ff;
        rd_idx = axi_req.araddr[MIC_IDX_MSB:MIC_IDX_LSB];
        rd_clr_evt = 1'b0;
        rd_end_data = 1'b0;
        rd_byte = 8'h00;
        rd_half = 16'h0000;
        evt_clr = 1'b0;
        evt_active = 1'b0;

        // write address and data accepted in either order
        if (axi_req.awvalid && st_ff.awready) begin
            nxt_st.aw_full = 1'b1;
            nxt_st.aw_idx = axi_req.awaddr[MIC_IDX_MSB:MIC_IDX_LSB];
        end
        if (axi_req.wvalid && st_ff.wready) begin
            nxt_st.w_full = 1'b1;
            nxt_st.w_data = axi_req.wdata[7:0];
            nxt_st.w_strb0 = axi_req.wstrb[0];
        end
        if (st_ff.bvalid && axi_req.bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // perform the write once both halves are held
        if (st_ff.aw_full && st_ff.w_full && !st_ff.bvalid) begin
            nxt_st.aw_full = 1'b0;
            nxt_st.w_full = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = reg_mapped(st_ff.aw_idx) ? MIC_RESP_OKAY
                : MIC_RESP_SLVERR;
            // only lane 0 carries register bits
            if (st_ff.w_strb0) begin
                unique case (st_ff.aw_idx)
                    MIC_IDX_EVENT_STATUS:
                        nxt_st.latch = st_ff.w_data[MIC_ST_LATCH];
                    MIC_IDX_AXIS_ENABLE:
                        nxt_st.axis_en = st_ff.w_data;
                    MIC_IDX_PIN_CONFIG:
                        nxt_st.pin_cfg = st_ff.w_data;
                    MIC_IDX_LOW_THR:
                        nxt_st.low_thr = st_ff.w_data;
                    MIC_IDX_HIGH_THR:
                        nxt_st.high_thr = st_ff.w_data;
                    default: ;
                endcase
            end
        end

        // read channel; side effects happen when the address is taken
        if (st_ff.rvalid && axi_req.rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = reg_mapped(rd_idx) ? MIC_RESP_OKAY
                : MIC_RESP_SLVERR;
            unique case (rd_idx)
                MIC_IDX_DATA_X:
                    rd_half = st_ff.data.x;
                MIC_IDX_DATA_Y:
                    rd_half = st_ff.data.y;
                MIC_IDX_DATA_Z:
                    rd_half = st_ff.data.z;
                MIC_IDX_HALL: begin
                    rd_half = st_ff.data.hall;
                    rd_end_data = 1'b1; // hall is last of the readout
                end
                MIC_IDX_SAMPLE_READY:
                    rd_byte = {7'h00, st_ff.rdy_st};
                MIC_IDX_EVENT_STATUS: begin
                    rd_byte[MIC_ST_LOW_X] = st_ff.low_st[0];
                    rd_byte[MIC_ST_LATCH] = st_ff.latch;
                    rd_byte[MIC_ST_LOW_Y] = st_ff.low_st[1];
                    rd_byte[MIC_ST_LOW_Z] = st_ff.low_st[2];
                    rd_byte[MIC_ST_HIGH_X] = st_ff.high_st[0];
                    rd_byte[MIC_ST_HIGH_Y] = st_ff.high_st[1];
                    rd_byte[MIC_ST_OVERFLOW] = st_ff.ovf_st;
                    rd_byte[MIC_ST_HIGH_Z] = st_ff.high_st[2];
                    rd_clr_evt = 1'b1;
                end
                MIC_IDX_AXIS_ENABLE:
                    rd_byte = st_ff.axis_en;
                MIC_IDX_PIN_CONFIG:
                    rd_byte = st_ff.pin_cfg;
                MIC_IDX_LOW_THR:
                    rd_byte = st_ff.low_thr;
                MIC_IDX_HIGH_THR:
                    rd_byte = st_ff.high_thr;
                default: ;
            endcase
            nxt_st.rdata = {16'h0000, rd_half | {8'h00, rd_byte}};
        end

        // status read clears only in latched mode
        evt_clr = rd_clr_evt && st_ff.latch;

        // status update; a new set beats a clear in the same cycle
        if (sample_valid) begin
            nxt_st.data = sample;
            nxt_st.rdy_st = 1'b1;
            if (st_ff.latch) begin
                nxt_st.low_st = ((st_ff.low_st & ~{3{evt_clr}})
                    | (low_cond & low_en)) & low_en;
                nxt_st.high_st = ((st_ff.high_st & ~{3{evt_clr}})
                    | (high_cond & high_en)) & high_en;
                nxt_st.ovf_st = (st_ff.ovf_st && !evt_clr)
                    || ovf_cond;
            end else begin
                nxt_st.low_st = low_cond & low_en;
                nxt_st.high_st = high_cond & high_en;
                nxt_st.ovf_st = ovf_cond;
            end
        end else begin
            if (evt_clr) begin
                nxt_st.low_st = 3'h0;
                nxt_st.high_st = 3'h0;
                nxt_st.ovf_st = 1'b0;
            end
            if (rd_end_data) begin
                nxt_st.rdy_st = 1'b0;
            end
        end

        // pins follow the new status with no extra cycle
        evt_active = (|nxt_st.low_st) || (|nxt_st.high_st)
            || (nxt_st.ovf_st && nxt_st.axis_en[MIC_EN_OVERFLOW]);
        nxt_st.evt_out = evt_active
            ^ ~nxt_st.pin_cfg[MIC_CFG_EVT_POL];
        nxt_st.evt_oe = nxt_st.pin_cfg[MIC_CFG_EVT_PIN_EN];
        nxt_st.rdy_out = nxt_st.rdy_st
            ^ ~nxt_st.pin_cfg[MIC_CFG_RDY_POL];
        nxt_st.rdy_oe = nxt_st.pin_cfg[MIC_CFG_RDY_PIN_EN];

        // one transaction per channel in flight
        nxt_st.awready = !nxt_st.aw_full && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_full && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; ce low freezes everything including the bus
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.axis_en <= MIC_AXIS_ENABLE_RST;
            st_ff.pin_cfg <= MIC_PIN_CONFIG_RST;
            st_ff.low_thr <= MIC_THR_RST;
            st_ff.high_thr <= MIC_THR_RST;
            st_ff.latch <= MIC_LATCH_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign axi_rsp.awready = st_ff.awready;
    assign axi_rsp.wready = st_ff.wready;
    assign axi_rsp.bvalid = st_ff.bvalid;
    assign axi_rsp.bresp = st_ff.bresp;
    assign axi_rsp.arready = st_ff.arready;
    assign axi_rsp.rvalid = st_ff.rvalid;
    assign axi_rsp.rdata = st_ff.rdata;
    assign axi_rsp.rresp = st_ff.rresp;
    assign field_event_pin_out = st_ff.evt_out;
    assign field_event_pin_oe = st_ff.evt_oe;
    assign sample_ready_pin_out = st_ff.rdy_out;
    assign sample_ready_pin_oe = st_ff.rdy_oe;

endmodule // mic_magnetometer_interrupt_controller

// ---- mic_pkg.sv ----
package mic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned MIC_ADDR_W = 12;
    localparam int unsigned MIC_DATA_W = 32;
    localparam int unsigned MIC_IDX_LSB = 2;
    localparam int unsigned MIC_IDX_MSB = 9;

    // register indices; byte address is four times the index
    localparam logic [7:0] MIC_IDX_DATA_X = 8'h40;
    localparam logic [7:0] MIC_IDX_DATA_Y = 8'h41;
    localparam logic [7:0] MIC_IDX_DATA_Z = 8'h42;
    localparam logic [7:0] MIC_IDX_HALL = 8'h43;
    localparam logic [7:0] MIC_IDX_SAMPLE_READY = 8'h48;
    localparam logic [7:0] MIC_IDX_EVENT_STATUS = 8'h4A;
    localparam logic [7:0] MIC_IDX_AXIS_ENABLE = 8'h4D;
    localparam logic [7:0] MIC_IDX_PIN_CONFIG = 8'h4E;
    localparam logic [7:0] MIC_IDX_LOW_THR = 8'h4F;
    localparam logic [7:0] MIC_IDX_HIGH_THR = 8'h50;

    // event_status field positions
    localparam int unsigned MIC_ST_LOW_X = 0;
    localparam int unsigned MIC_ST_LATCH = 1;
    localparam int unsigned MIC_ST_LOW_Y = 2;
    localparam int unsigned MIC_ST_LOW_Z = 3;
    localparam int unsigned MIC_ST_HIGH_X = 4;
    localparam int unsigned MIC_ST_HIGH_Y = 5;
    localparam int unsigned MIC_ST_OVERFLOW = 6;
    localparam int unsigned MIC_ST_HIGH_Z = 7;

    // event_axis_enable: [2:0] low xyz, [5:3] high xyz (active low)
    localparam int unsigned MIC_EN_LOW_LSB = 0;
    localparam int unsigned MIC_EN_HIGH_LSB = 3;
    localparam int unsigned MIC_EN_OVERFLOW = 6;

    // event_pin_config field positions
    localparam int unsigned MIC_CFG_EVT_POL = 0;
    localparam int unsigned MIC_CFG_RDY_POL = 2;
    localparam int unsigned MIC_CFG_EVT_PIN_EN = 6;
    localparam int unsigned MIC_CFG_RDY_PIN_EN = 7;

    // reset values
    localparam logic [7:0] MIC_AXIS_ENABLE_RST = 8'h3F;
    localparam logic [7:0] MIC_PIN_CONFIG_RST = 8'h05;
    localparam logic [7:0] MIC_THR_RST = 8'h00;
    localparam logic MIC_LATCH_RST = 1'b1;

    // saturated overflow codes and threshold scale shift (x16)
    localparam logic [15:0] MIC_OVF_XY = 16'hF000;
    localparam logic [15:0] MIC_OVF_Z = 16'hC000;
    localparam int unsigned MIC_THR_SHIFT = 4;

    // bus responses
    localparam logic [1:0] MIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MIC_RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // one complete measurement set
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
        logic [15:0] hall;
    } mic_sample_type;

    // master to slave
    typedef struct packed {
        logic awvalid;
        logic [MIC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [MIC_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [MIC_ADDR_W-1:0] araddr;
        logic rready;
    } mic_axi_req_type;

    // slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [MIC_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } mic_axi_rsp_type;

endpackage

// ---- mic_host_pins.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// host side of the two event pins, weak pull-ups on both lines
module mic_host_pins (
    input wire logic evt_out,
    input wire logic evt_oe,
    input wire logic rdy_out,
    input wire logic rdy_oe,
    output logic evt_lvl,
    output logic rdy_lvl
);
    // a released pin floats to the pull-up, never the last driven value
    assign evt_lvl = evt_oe ? evt_out : 1'b1;
    assign rdy_lvl = rdy_oe ? rdy_out : 1'b1;
endmodule // mic_host_pins

// ---- mic_checker_sva.sv ----
`timescale 1ns/1ps
module mic_checker_sva
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire mic_axi_req_type axi_req,
    input wire mic_axi_rsp_type axi_rsp,
    input wire logic sample_valid,
    input wire mic_sample_type sample,
    input wire logic field_event_pin_out,
    input wire logic field_event_pin_oe,
    input wire logic sample_ready_pin_out,
    input wire logic sample_ready_pin_oe
);
    logic rpol_ff;
    logic aw_go;
    logic w_go;
    logic ar_go;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    // handshakes as the slave sees them
    assign aw_go = ce && axi_req.awvalid && axi_rsp.awready;
    assign w_go = ce && axi_req.wvalid && axi_rsp.wready;
    assign ar_go = ce && axi_req.arvalid && axi_rsp.arready;
    // mirror of ready polarity; ahead of the device by one edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rpol_ff <= MIC_PIN_CONFIG_RST[MIC_CFG_RDY_POL];
        end else if (aw_go && w_go && axi_req.wstrb[0] &&
            axi_req.awaddr[9:2] == MIC_IDX_PIN_CONFIG) begin
            rpol_ff <= axi_req.wdata[MIC_CFG_RDY_POL];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_evt_oe_cfg: assert property (
        $changed(field_event_pin_oe) |-> $past(axi_req.wvalid, 2) &&
        field_event_pin_oe == $past(axi_req.wdata[6], 2))
        else $error("event pin enable moved without config write");
    a_rdy_oe_cfg: assert property (
        $changed(sample_ready_pin_oe) |-> $past(axi_req.wvalid, 2) &&
        sample_ready_pin_oe == $past(axi_req.wdata[7], 2))
        else $error("ready pin enable moved without config write");
    a_evt_pin_cause: assert property (
        $changed(field_event_pin_out) |-> $past(sample_valid) ||
        $past(axi_req.arvalid) || $past(axi_req.wvalid, 2))
        else $error("event pin moved with no measurement or access");
    a_rdy_pin_cause: assert property (
        $changed(sample_ready_pin_out) |-> $past(sample_valid) ||
        $past(axi_req.arvalid) || $past(axi_req.wvalid, 2))
        else $error("ready pin moved with no measurement or access");
    a_rdy_after_sample: assert property (
        sample_valid && ce |=> sample_ready_pin_out == rpol_ff)
        else $error("ready pin not active after measurement");
    a_pins_float_rst: assert property (
        $fell(rst) |-> !field_event_pin_oe && !sample_ready_pin_oe)
        else $error("pins driven straight after reset");
    a_write_resp: assert property (
        aw_go && w_go |=> ##1 axi_rsp.bvalid)
        else $error("write response late");
    a_read_resp: assert property (
        ar_go |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read response late");
    c_sample: cover property (sample_valid);
    c_evt_rise: cover property ($rose(field_event_pin_out));
    c_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp[1]);
endmodule // mic_checker_sva

bind mic_magnetometer_interrupt_controller mic_checker_sva u_chk (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .sample_valid(sample_valid), .sample(sample),
    .field_event_pin_out(field_event_pin_out),
    .field_event_pin_oe(field_event_pin_oe),
    .sample_ready_pin_out(sample_ready_pin_out),
    .sample_ready_pin_oe(sample_ready_pin_oe));

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import mic_pkg::*;
    logic ref_clk, rst, sample_valid, e_out, e_oe, r_out, r_oe, e_lvl, r_lvl;
    logic ce;
    mic_axi_req_type req;
    mic_axi_rsp_type rsp;
    mic_sample_type sample;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    localparam logic [1:0] OK = MIC_RESP_OKAY;
    mic_magnetometer_interrupt_controller DUT (.ref_clk(ref_clk),
        .rst(rst), .ce(ce), .axi_req(req), .axi_rsp(rsp),
        .sample_valid(sample_valid), .sample(sample),
        .field_event_pin_out(e_out), .field_event_pin_oe(e_oe),
        .sample_ready_pin_out(r_out), .sample_ready_pin_oe(r_oe));
    mic_host_pins u_host (.evt_out(e_out), .evt_oe(e_oe), .rdy_out(r_out),
        .rdy_oe(r_oe), .evt_lvl(e_lvl), .rdy_lvl(r_lvl));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // aw and w offered together, each dropped when its own ready is seen
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
        input logic [1:0] er);
        @(posedge ref_clk);
        req.awaddr <= {2'h0, idx, 2'h0};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (req.awvalid || req.wvalid) begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        while (!rsp.bvalid) @(posedge ref_clk);
        chk({30'h0, rsp.bresp}, {30'h0, er});
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
        input logic [1:0] er);
        @(posedge ref_clk);
        req.araddr <= {2'h0, idx, 2'h0};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge ref_clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rsp.rvalid);
        chk(rsp.rdata, exp);
        chk({30'h0, rsp.rresp}, {30'h0, er});
        req.rready <= 1'b0;
    endtask
    // one complete x, y, z, hall set as a single-cycle pulse
    task automatic smp(input logic [15:0] x, y, z);
        @(posedge ref_clk);
        sample <= {x, y, z, 16'h0000};
        sample_valid <= 1'b1;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
    endtask
    // pins read mid-cycle: {event oe, event level, ready oe, ready level}
    task automatic pin(input logic [3:0] exp);
        @(negedge ref_clk);
        chk({28'h0, e_oe, e_lvl, r_oe, r_lvl}, {28'h0, exp});
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // under two hundred cycles expected; a hang is cut off well beyond that
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        sample = '0;
        sample_valid = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h4D, 32'h3F, OK);
        rd(8'h4E, 32'h05, OK);
        rd(8'h4A, 32'h02, OK);
        rd(8'h48, 32'h00, OK);
        pin(4'h5);
        $display("test reset done");
        wr(8'h4E, 8'hC5, OK);
        wr(8'h4F, 8'h02, OK);
        wr(8'h4D, 8'h38, OK);
        smp(16'hF000, 16'h000A, 16'hFF00);
        pin(4'hF);
        rd(8'h4A, 32'h4E, OK);
        pin(4'hB);
        rd(8'h4A, 32'h02, OK);
        $display("test low latched done");
        wr(8'h50, 8'h01, OK);
        wr(8'h4D, 8'h07, OK);
        smp(16'h0011, 16'h0010, 16'h7FFF);
        rd(8'h4A, 32'h92, OK);
        $display("test high done");
        wr(8'h4A, 8'h00, OK);
        smp(16'h0011, 16'h0010, 16'h7FFF);
        rd(8'h4A, 32'h90, OK);
        rd(8'h4A, 32'h90, OK);
        pin(4'hF);
        smp(16'h0000, 16'h0000, 16'h0000);
        rd(8'h4A, 32'h00, OK);
        pin(4'hB);
        smp(16'h0011, 16'h0000, 16'h0000);
        wr(8'h4D, 8'h3F, OK);
        rd(8'h4A, 32'h10, OK);
        smp(16'h0011, 16'h0000, 16'h0000);
        rd(8'h4A, 32'h00, OK);
        $display("test non-latched done");
        smp(16'hF000, 16'h0000, 16'h0000);
        rd(8'h4A, 32'h40, OK);
        pin(4'hB);
        wr(8'h4D, 8'h7F, OK);
        smp(16'hF000, 16'h0000, 16'h0000);
        pin(4'hF);
        $display("test overflow done");
        wr(8'h4E, 8'hC0, OK);
        smp(16'hF000, 16'h0000, 16'h0000);
        pin(4'hA);
        rd(8'h48, 32'h01, OK);
        rd(8'h40, 32'hF000, OK);
        rd(8'h43, 32'h0000, OK);
        pin(4'hB);
        rd(8'h48, 32'h00, OK);
        wr(8'h4E, 8'h00, OK);
        pin(4'h5);
        $display("test polarity ready done");
        rd(8'h4B, 32'h00, MIC_RESP_SLVERR);
        wr(8'h4C, 8'hFF, MIC_RESP_SLVERR);
        rd(8'h4F, 32'h02, OK);
        $display("test unmapped done");
        // a measurement offered while ce is low must leave no trace
        ce <= 1'b0;
        smp(16'h0011, 16'h0000, 16'h0000);
        ce <= 1'b1;
        rd(8'h48, 32'h00, OK);
        rd(8'h4A, 32'h40, OK);
        $display("test clock enable done");
        stop_test();
    end
endmodule // tb
